// ==== hdl/pulse_width_timer.sv ====
// Pulse width timer: 16-bit up counter used as interval timer or as
// pulse width / cycle measurement unit, with AHB-Lite register slave.
// Assumes a single 25 MHz clock, synchronous reset, one AHB-Lite master.
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pulse_width_timer (
  input  wire logic        clk,        // System clock, 25 MHz
  input  wire logic        rst,        // Synchronous reset, active high
  input  wire logic        hsel,       // AHB slave select
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB bus ready
  output logic [31:0]      hrdata,     // AHB read data
  output logic             hreadyout,  // AHB slave ready
  output logic             hresp,      // AHB response
  input  wire logic        count_in,   // External pulse input pin
  output logic             pulse_out,  // Timer pulse output pin
  output logic             irq         // Interrupt, level high
);
  // Register state
  logic [10:1]              ctrl;       // Control fields above run bit
  logic                     run;        // Run bit
  logic [15:0]              reload;     // Reload value
  logic [15:0]              count;      // Main counter
  logic [15:0]              result;     // Captured measurement
  logic [1:0]               status;     // Sticky events
  logic [1:0]               mask;       // Interrupt mask
  logic [4:0]               pre;        // Internal clock prescaler
  logic                     sig_d;      // Delayed measured signal
  logic                     start_pol;  // Measurement started on rise
  pwt_pkg::meas_state_e     state;      // Measurement sequencer
  // Bus address phase capture
  logic                     ap_wr;      // Pending write data phase
  logic [7:0]               ap_addr;    // Pending write offset
  logic                     sig;        // Measured signal from input stage

  // Control field views
  wire       meas_mode = ctrl[pwt_pkg::CTRL_MODE];
  wire [1:0] clk_sel   = ctrl[pwt_pkg::CTRL_CLK_LO +: 2];
  wire [2:0] mm        = ctrl[pwt_pkg::CTRL_MM_LO +: 3];
  wire       cont      = ctrl[pwt_pkg::CTRL_CONT];
  wire [2:0] div_sel   = ctrl[pwt_pkg::CTRL_DIV_LO +: 3];

  // Tick from prescaler for a given clock select
  function automatic logic tick_of(input logic [1:0] sel, input logic [4:0] p);
    logic t;
    t = &p;
    if (sel == pwt_pkg::CLK_DIV2) begin
      t = p[0];
    end else if (sel == pwt_pkg::CLK_DIV8) begin
      t = &p[2:0];
    end
    return t;
  endfunction : tick_of

  // Input stage: synchroniser and divider
  pwt_input_divider u_div (
    .clk     (clk),
    .rst     (rst),
    .pin_in  (count_in),
    .div_sel (div_sel),
    .sig_out (sig)
  );

  // Bus decode
  wire        ap_take   = hsel & htrans[1] & hready;
  wire        wr_ctrl   = ap_wr & (ap_addr == pwt_pkg::OFS_CTRL);
  wire        wr_reload = ap_wr & (ap_addr == pwt_pkg::OFS_RELOAD);
  wire        wr_status = ap_wr & (ap_addr == pwt_pkg::OFS_STATUS);
  wire        wr_mask   = ap_wr & (ap_addr == pwt_pkg::OFS_MASK);
  wire [7:0]  rd_addr   = haddr[7:0];
  // Read mux, unmapped offsets read zero
  wire [31:0] rd_data   =
    (rd_addr == pwt_pkg::OFS_CTRL)   ? {21'h000000, ctrl, run} :
    (rd_addr == pwt_pkg::OFS_RELOAD) ? {16'h0000, reload} :
    (rd_addr == pwt_pkg::OFS_COUNT)  ? {16'h0000, count} :
    (rd_addr == pwt_pkg::OFS_RESULT) ? {16'h0000, result} :
    (rd_addr == pwt_pkg::OFS_STATUS) ? {29'h00000000, (state != pwt_pkg::S_IDLE), status} :
    (rd_addr == pwt_pkg::OFS_MASK)   ? {30'h00000000, mask} : 32'h00000000;

  // Edges of the measured signal
  wire rise = sig & ~sig_d;
  wire fall = ~sig & sig_d;
  wire tick = tick_of(clk_sel, pre);
  // start and stop edge per mode
  wire start_edge = (mm == pwt_pkg::MM_HIGH | mm == pwt_pkg::MM_CYC_RISE) ? rise :
                    (mm == pwt_pkg::MM_LOW  | mm == pwt_pkg::MM_CYC_FALL) ? fall :
                    (rise | fall);
  wire stop_edge  = (mm == pwt_pkg::MM_HIGH | mm == pwt_pkg::MM_CYC_FALL) ? fall :
                    (mm == pwt_pkg::MM_LOW  | mm == pwt_pkg::MM_CYC_RISE) ? rise :
                    (start_pol ? fall : rise);
  // Stop edge doubles as next start in cycle and edge modes
  wire chain      = (mm != pwt_pkg::MM_HIGH) & (mm != pwt_pkg::MM_LOW);
  wire start_req  = wr_ctrl & hwdata[pwt_pkg::CTRL_RUN];
  wire timer_run  = run & ~meas_mode;
  wire counting   = run & meas_mode & (state == pwt_pkg::S_COUNT);
  wire arm_hit    = run & meas_mode & (state == pwt_pkg::S_ARM) & start_edge;
  wire evt_done   = counting & stop_edge & ~wr_ctrl;
  wire cnt_tick   = tick & (timer_run | counting) & ~wr_ctrl;
  wire evt_ovf    = cnt_tick & (count == pwt_pkg::COUNT_MAX);
  wire [15:0] next_count =
    start_req               ? (hwdata[pwt_pkg::CTRL_MODE] ? 16'h0000 : reload) :
    (evt_done | arm_hit)    ? 16'h0000 :
    (evt_ovf & timer_run)   ? reload :
    cnt_tick                ? count + 16'h0001 : count;

  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture and registered read data
  always_ff @(posedge clk) begin
    if (rst) begin
      ap_wr   <= 1'b0;
      ap_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      ap_wr   <= ap_take & hwrite;
      ap_addr <= haddr[7:0];
      hrdata  <= (ap_take & ~hwrite) ? rd_data : 32'h00000000;
    end
  end

  // Control and reload registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl   <= pwt_pkg::CTRL_RST[10:1];
      reload <= pwt_pkg::RELOAD_RST;
      mask   <= pwt_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[10:1];
      end
      if (wr_reload) begin
        reload <= hwdata[15:0];
      end
      if (wr_mask) begin
        mask <= hwdata[1:0];
      end
    end
  end

  // Run bit: software write wins over hardware stop
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= pwt_pkg::CTRL_RST[pwt_pkg::CTRL_RUN];
    end else if (wr_ctrl) begin
      run <= hwdata[pwt_pkg::CTRL_RUN];
    end else if (evt_done & ~cont) begin
      run <= 1'b0;
    end
  end

  // Prescaler and signal history
  always_ff @(posedge clk) begin
    if (rst) begin
      pre   <= 5'h00;
      sig_d <= 1'b0;
    end else begin
      pre   <= pre + 5'h01;
      sig_d <= sig;
    end
  end

  // Main counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  // pulse output toggles on each period end
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_out <= 1'b0;
    end else if (start_req) begin
      pulse_out <= 1'b0;
    end else if (evt_ovf & timer_run) begin
      pulse_out <= ~pulse_out;
    end
  end

  // Measurement sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= pwt_pkg::S_IDLE;
      start_pol <= 1'b0;
    end else if (wr_ctrl) begin
      state <= (hwdata[pwt_pkg::CTRL_RUN] & hwdata[pwt_pkg::CTRL_MODE]) ? pwt_pkg::S_ARM : pwt_pkg::S_IDLE;
    end else begin
      case (state)
        pwt_pkg::S_IDLE: begin
          state <= pwt_pkg::S_IDLE;
        end
        pwt_pkg::S_ARM: begin
          // Wait for start edge
          if (arm_hit) begin
            state     <= pwt_pkg::S_COUNT;
            start_pol <= rise;
          end
        end
        pwt_pkg::S_COUNT: begin
          if (evt_done) begin
            start_pol <= rise;
            if (!cont) begin
              state <= pwt_pkg::S_IDLE;
            end else if (chain) begin
              state <= pwt_pkg::S_COUNT;
            end else begin
              state <= pwt_pkg::S_ARM;
            end
          end
        end
        default: begin
          state <= pwt_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result <= 16'h0000;
    end else if (evt_done) begin
      result <= count;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~(wr_status ? hwdata[1:0] : 2'h0)) | {evt_done, evt_ovf};
    end
  end

  // Interrupt output
  wire [1:0] next_status_irq = ((status & ~(wr_status ? hwdata[1:0] : 2'h0)) | {evt_done, evt_ovf}) & mask;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status_irq);
    end
  end

  // Checks
  property p_reload;
    @(posedge clk) disable iff (rst)
    (evt_ovf && timer_run && !wr_reload) |=> (count == $past(reload)) && status[pwt_pkg::ST_OVF];
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload on overflow");

  property p_pulse;
    @(posedge clk) disable iff (rst)
    (evt_ovf && timer_run) |=> (pulse_out != $past(pulse_out));
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse output did not toggle");

  property p_count_up;
    @(posedge clk) disable iff (rst)
    (cnt_tick && !evt_ovf && !evt_done) |=> (count == $past(count) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step up");

  property p_done_irq;
    @(posedge clk) disable iff (rst)
    (evt_done && mask[pwt_pkg::ST_DONE]) |=> irq && status[pwt_pkg::ST_DONE];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done did not raise interrupt");

  property p_result;
    @(posedge clk) disable iff (rst)
    evt_done |=> (result == $past(count)) ##1 ($past(evt_done) || result == $past(result));
  endproperty
  a_result: assert property (p_result) else $error("result not captured or not held");

  property p_single;
    @(posedge clk) disable iff (rst)
    (evt_done && !cont) |=> !run && (state == pwt_pkg::S_IDLE);
  endproperty
  a_single: assert property (p_single) else $error("single measurement did not stop");

  property p_tick_div8;
    @(posedge clk) disable iff (rst)
    (tick && clk_sel == pwt_pkg::CLK_DIV8 && !wr_ctrl) |=> (!tick || clk_sel != pwt_pkg::CLK_DIV8) [*7];
  endproperty
  a_tick_div8: assert property (p_tick_div8) else $error("clk/8 tick spacing wrong");

  property p_high_start;
    @(posedge clk) disable iff (rst)
    (arm_hit && mm == pwt_pkg::MM_HIGH) |-> rise ##1 (state == pwt_pkg::S_COUNT && count == 16'h0000);
  endproperty
  a_high_start: assert property (p_high_start) else $error("high width start wrong");

  property p_cycle_stop;
    @(posedge clk) disable iff (rst)
    (counting && !wr_ctrl && mm == pwt_pkg::MM_CYC_RISE && rise) |-> evt_done;
  endproperty
  a_cycle_stop: assert property (p_cycle_stop) else $error("rise cycle did not complete");

  property p_edge_same;
    @(posedge clk) disable iff (rst)
    (counting && !wr_ctrl && mm == pwt_pkg::MM_EDGE && (rise || fall))
      |-> (evt_done == (start_pol ? fall : rise));
  endproperty
  a_edge_same: assert property (p_edge_same) else $error("edge mode stop edge wrong");

  property p_meas_tick;
    @(posedge clk) disable iff (rst)
    (counting && cnt_tick && !stop_edge && !evt_ovf) |=> (count == $past(count) + 16'h0001);
  endproperty
  a_meas_tick: assert property (p_meas_tick) else $error("measurement missed a tick");

  c_ovf:    cover property (@(posedge clk) disable iff (rst) evt_ovf && timer_run);
  c_done:   cover property (@(posedge clk) disable iff (rst) evt_done && cont);
  c_single: cover property (@(posedge clk) disable iff (rst) evt_done && !cont);
  c_edge:   cover property (@(posedge clk) disable iff (rst) evt_done && mm == pwt_pkg::MM_EDGE);
endmodule : pulse_width_timer
`default_nettype wire

// ==== hdl/pwt_input_divider.sv ====
// Input stage: synchronises the count input pin and optionally divides it.
// Assumes the pin is asynchronous to clk; output is a registered level.
`timescale 1ns/1ps
`default_nettype none
module pwt_input_divider (
  input  wire logic       clk,      // System clock
  input  wire logic       rst,      // Synchronous reset, active high
  input  wire logic       pin_in,   // Raw count input pin
  input  wire logic [2:0] div_sel,  // Divider select
  output logic            sig_out   // Measured signal
);
  logic       sync1;                // First synchroniser stage
  logic       sync2;                // Second synchroniser stage
  logic       sync2_d;              // Delayed copy for edge detect
  logic [2:0] sel_d;                // Divider select in use
  logic [7:0] div_cnt;              // Rising edge counter
  wire        pin_rise = sync2 & ~sync2_d;
  // New select restarts the count, so a stale phase cannot fake an edge
  wire        sel_new  = (div_sel != sel_d);
  // Divided level: one bit of the edge counter, period 2^n input cycles
  wire        div_level = (sel_d == pwt_pkg::DIV_4)   ? div_cnt[1] :
                          (sel_d == pwt_pkg::DIV_16)  ? div_cnt[3] :
                          (sel_d == pwt_pkg::DIV_64)  ? div_cnt[5] :
                          (sel_d == pwt_pkg::DIV_256) ? div_cnt[7] : sync2;

  // Two-stage synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1   <= 1'b0;
      sync2   <= 1'b0;
      sync2_d <= 1'b0;
    end else begin
      sync1   <= pin_in;
      sync2   <= sync1;
      sync2_d <= sync2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 8'h00;
      sel_d   <= pwt_pkg::DIV_OFF;
    end else begin
      sel_d <= div_sel;
      // Select change: restart from zero
      if (sel_new) begin
        div_cnt <= 8'h00;
      end else if (pin_rise) begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Registered output level
  always_ff @(posedge clk) begin
    if (rst) begin
      sig_out <= 1'b0;
    end else begin
      sig_out <= div_level;
    end
  end

  property p_div4_step;
    @(posedge clk) disable iff (rst)
    (pin_rise && !sel_new && sel_d == pwt_pkg::DIV_4 && div_cnt[1:0] == 2'h1) |=> ##1 (sig_out == 1'b1);
  endproperty
  a_div4_step: assert property (p_div4_step) else $error("divided level did not rise after second edge");
endmodule : pwt_input_divider
`default_nettype wire

// ==== hdl/pwt_pkg.sv ====
// Package for the pulse width timer: register map, field layout, codes, timing.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
package pwt_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;  // Control and run bit
  localparam logic [7:0]  OFS_RELOAD  = 8'h04;  // Timer reload value
  localparam logic [7:0]  OFS_COUNT   = 8'h08;  // Live counter, read only
  localparam logic [7:0]  OFS_RESULT  = 8'h0C;  // Captured measurement, read only
  localparam logic [7:0]  OFS_STATUS  = 8'h10;  // Sticky events, write one to clear
  localparam logic [7:0]  OFS_MASK    = 8'h14;  // Interrupt mask
  // Control field positions
  localparam int          CTRL_RUN    = 0;      // Run / start bit
  localparam int          CTRL_MODE   = 1;      // 0 timer, 1 measurement
  localparam int          CTRL_CLK_LO = 2;      // Count clock select [3:2]
  localparam int          CTRL_MM_LO  = 4;      // Measurement mode [6:4]
  localparam int          CTRL_CONT   = 7;      // Consecutive measurement
  localparam int          CTRL_DIV_LO = 8;      // Input divider select [10:8]
  localparam int          CTRL_WIDTH  = 11;     // Implemented control bits
  // Status bit positions
  localparam int          ST_OVF      = 0;      // Counter overflow
  localparam int          ST_DONE     = 1;      // Measurement complete
  localparam int          ST_BUSY     = 2;      // Measurement armed or counting
  // Reset values
  localparam logic [10:0] CTRL_RST    = 11'h000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  // Count clock selects: clk/2, clk/8, clk/32
  localparam logic [1:0]  CLK_DIV2    = 2'h0;
  localparam logic [1:0]  CLK_DIV8    = 2'h1;
  localparam logic [1:0]  CLK_DIV32   = 2'h2;
  localparam int          PRE_WIDTH   = 5;      // Internal prescaler bits
  // Measurement modes
  localparam logic [2:0]  MM_HIGH     = 3'h0;   // Rise to fall
  localparam logic [2:0]  MM_LOW      = 3'h1;   // Fall to rise
  localparam logic [2:0]  MM_CYC_RISE = 3'h2;   // Rise to rise
  localparam logic [2:0]  MM_CYC_FALL = 3'h3;   // Fall to fall
  localparam logic [2:0]  MM_EDGE     = 3'h4;   // Any edge to opposite edge
  // Input divider selects: off, 2^2, 2^4, 2^6, 2^8
  localparam logic [2:0]  DIV_OFF     = 3'h0;
  localparam logic [2:0]  DIV_4       = 3'h1;
  localparam logic [2:0]  DIV_16      = 3'h2;
  localparam logic [2:0]  DIV_64      = 3'h3;
  localparam logic [2:0]  DIV_256     = 3'h4;
  localparam int          DIV_WIDTH   = 8;      // Input divider counter bits
  // Measurement sequencer states
  typedef enum logic [1:0] {
    S_IDLE,
    S_ARM,
    S_COUNT
  } meas_state_e;
endpackage : pwt_pkg

// ==== test/pulse_width_timer_test.sv ====
// Self-checking bench for the pulse width timer.
// Assumes a 25 MHz clock, an AHB-Lite master here, the pulse source model.
`timescale 1ns/1ps
`default_nettype none
module pulse_width_timer_test;
  logic        clk;        // System clock
  logic        rst;        // Sync reset
  logic        hsel;       // Slave select
  logic [31:0] haddr;      // Address
  logic [1:0]  htrans;     // Transfer type
  logic        hwrite;     // Write flag
  logic [2:0]  hsize;      // Transfer size
  logic [31:0] hwdata;     // Write data
  wire logic   hready;     // Bus ready
  logic [31:0] hrdata;     // Read data
  logic        hreadyout;  // Slave ready
  logic        hresp;      // Response
  logic        count_in;   // Input pin
  logic        pulse_out;  // Timer output
  logic        irq;        // Interrupt
  int          failures;   // Mismatch count
  int          num_checks; // Compare count
  int          cycles;     // Timeout count
  logic [31:0] rd;         // Last read data
  localparam int LIMIT = 40000; // Cycle ceiling

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  pulse_width_timer dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .count_in(count_in), .pulse_out(pulse_out), .irq(irq));
  pulse_source src_u (.clk(clk), .count_in(count_in));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  // Counts and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One if seen lies within one tick of exp
  function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] e);
    return {31'h0, (s + 32'h1 >= e) && (s <= e + 32'h1)};
  endfunction : near

  // Control word: run set, then mode, clock, measure mode, cont, divider
  function automatic logic [31:0] ctl(input logic m, input logic [1:0] c,
      input logic [2:0] mm, input logic cont, input logic [2:0] dv);
    return {21'h0, dv, cont, mm, c, m, 1'b1};
  endfunction : ctl

  // One AHB single transfer; read data lands in rd
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  // Bounded wait for irq
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk);
  endtask : wait_irq

  // Cycles until pulse_out changes
  task automatic wait_toggle(output int n);
    logic p;
    p = pulse_out;
    n = 0;
    while (pulse_out === p && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_toggle

  // Arm, send a train, check result; c of zero keeps the control word
  task automatic measure(input logic [31:0] c, input int n, input int hi,
      input int lo, input logic [31:0] exp);
    xfer(pwt_pkg::OFS_STATUS, 1'b1, 32'h3);
    if (c != 32'h0) xfer(pwt_pkg::OFS_CTRL, 1'b1, c);
    src_u.pulses(n, hi, lo);
    wait_irq(200);
    check({31'h0, irq}, 32'h1);
    xfer(pwt_pkg::OFS_RESULT, 1'b0, 32'h0);
    check(near(rd, exp), 32'h1);
  endtask : measure

  // Reset values, unmapped and read-only places
  task automatic test_reset;
    for (int a = 0; a <= 24; a += 4) begin
      xfer(a[7:0], 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    check({29'h0, hresp, irq, pulse_out}, 32'h0);
    xfer(pwt_pkg::OFS_RELOAD, 1'b1, 32'h1234ABCD);
    xfer(pwt_pkg::OFS_RELOAD, 1'b0, 32'h0);
    check(rd, 32'h0000ABCD);
    xfer(pwt_pkg::OFS_RESULT, 1'b1, 32'h5555);
    xfer(pwt_pkg::OFS_RESULT, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask : test_reset

  // Timer periods per clock, overflow interrupt and mask
  task automatic test_timer;
    int n;
    xfer(pwt_pkg::OFS_RELOAD, 1'b1, 32'h0000FFF0);
    xfer(pwt_pkg::OFS_MASK, 1'b1, 32'h1);
    for (int c = 0; c < 3; c++) begin
      xfer(pwt_pkg::OFS_CTRL, 1'b1, ctl(1'b0, c[1:0], 3'h0, 1'b0, 3'h0));
      wait_toggle(n);
      wait_toggle(n);
      check(n, 32'd32 << (2 * c));
    end
    xfer(pwt_pkg::OFS_COUNT, 1'b0, 32'h0);
    check({31'h0, rd >= 32'hFFF0 && rd <= 32'hFFFF}, 32'h1);
    wait_toggle(n);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    xfer(pwt_pkg::OFS_STATUS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    xfer(pwt_pkg::OFS_MASK, 1'b1, 32'h0);
    wait_toggle(n);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    xfer(pwt_pkg::OFS_STATUS, 1'b0, 32'h0);
    check(rd & 32'h1, 32'h1);
    xfer(pwt_pkg::OFS_CTRL, 1'b1, 32'h0);
    xfer(pwt_pkg::OFS_STATUS, 1'b1, 32'h3);
    $display("test timer done");
  endtask : test_timer

  // All measure modes, single shot, clocks rotated
  task automatic test_modes;
    logic [31:0] ex [5] = '{32'd32, 32'd12, 32'd5, 32'd80, 32'd8};
    xfer(pwt_pkg::OFS_MASK, 1'b1, 32'h2);
    for (int m = 0; m < 5; m++) begin
      measure(ctl(1'b1, 2'(m % 3), m[2:0], 1'b0, 3'h0), 3, 64, 96, ex[m]);
      xfer(pwt_pkg::OFS_CTRL, 1'b0, 32'h0);
      check(rd & 32'h1, 32'h0);
      xfer(pwt_pkg::OFS_STATUS, 1'b0, 32'h0);
      check(rd & 32'h4, 32'h0);
    end
    $display("test modes done");
  endtask : test_modes

  // Input divider ratios on rise to rise cycles
  task automatic test_divider;
    for (int d = 1; d <= 4; d++) begin
      measure(ctl(1'b1, pwt_pkg::CLK_DIV2, pwt_pkg::MM_CYC_RISE, 1'b0, d[2:0]),
        3 << (2 * d), 4, 4, 32'h4 << (2 * d));
    end
    $display("test divider done");
  endtask : test_divider

  // Consecutive runs replace and then hold the result
  task automatic test_consec;
    measure(ctl(1'b1, pwt_pkg::CLK_DIV2, pwt_pkg::MM_CYC_RISE, 1'b1, 3'h0),
      3, 50, 50, 32'd50);
    xfer(pwt_pkg::OFS_CTRL, 1'b0, 32'h0);
    check(rd & 32'h1, 32'h1);
    measure(32'h0, 3, 30, 30, 32'd30);
    repeat (100) @(posedge clk);
    xfer(pwt_pkg::OFS_RESULT, 1'b0, 32'h0);
    check(near(rd, 32'd30), 32'h1);
    xfer(pwt_pkg::OFS_CTRL, 1'b1, 32'h0);
    $display("test consec done");
  endtask : test_consec

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_timer();
    test_modes();
    test_divider();
    test_consec();
    close_out();
  end
endmodule : pulse_width_timer_test
`default_nettype wire

// ==== test/pwt_pulse_source.sv ====
// Far-side model: a pulse source driving the count input pin.
// Assumes callers enter its task just after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input  wire logic clk,      // System clock
  output var  logic count_in  // Pulse level on the pin
);
  // Line rests low between trains
  initial count_in = 1'b0;

  // Train of n pulses, high and low times in clk cycles
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      count_in <= 1'b1;
      repeat (hi) @(posedge clk);
      count_in <= 1'b0;
      repeat (lo) @(posedge clk);
    end
  endtask : pulses
endmodule : pulse_source
`default_nettype wire
